// *** src/sfs_pkg.sv ***
// Package of constants and types for the flash command sequencer
`default_nettype none
package sfs_pkg;
  // ===========================================================
  // Widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BANK_W = 2;
  localparam int MA_W   = 12;
  localparam int COL_W  = 8;
  localparam int ROW_W  = 12;
  localparam int STAT_W = 8;
  // ===========================================================
  // Bus address field positions
  localparam int COL_LSB  = 0;
  localparam int ROW_LSB  = 8;
  localparam int BANK_LSB = 20;
  localparam int CODE_W   = 8;
  // ===========================================================
  // Command register codes placed on the low address bits
  localparam logic [7:0] CODE_PROGRAM = 8'h40;
  localparam logic [7:0] CODE_STATUS  = 8'h70;
  // ===========================================================
  // Memory commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_LCR    = 4'h0;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam logic [3:0] CMD_DESEL  = 4'hF;
  // ===========================================================
  // Timing limits and reset values
  localparam int CNT_W = 3;
  localparam logic [1:0] CL_MIN = 2'h1;
  localparam logic [1:0] CL_MAX = 2'h3;
  localparam logic [CNT_W-1:0] RCD_MIN = 3'h1;
  // ===========================================================
  // Sequencer states, Gray coded from idle through the row-to-column wait
  typedef enum logic [2:0] {
    SFS_IDLE   = 3'b000,
    SFS_LCR    = 3'b001,
    SFS_ACT    = 3'b011,
    SFS_RCD    = 3'b010,
    SFS_CMD    = 3'b110,
    SFS_LAT    = 3'b111,
    SFS_DONE   = 3'b101
  } sfs_state_type;
endpackage : sfs_pkg
`default_nettype wire

// *** src/sfs_delay_counter.sv ***
// Down counter that times waits in whole memory clocks
`timescale 1ns/10ps
`default_nettype none
module sfs_delay_counter (
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  // Control
  input  wire logic                      load_in,
  input  wire logic [sfs_pkg::CNT_W-1:0] value_in,
  // Status
  output logic                           zero_out
);
  import sfs_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    if (load_in) begin
      next_count = value_in;
    end else if (count != '0) begin
      next_count = count - 3'h1;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign zero_out = (count == '0);
endmodule : sfs_delay_counter
`default_nettype wire

// *** src/sfs_status_capture.sv ***
// Capture of the status byte from the low data lines
`timescale 1ns/10ps
`default_nettype none
module sfs_status_capture (
  // Clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  // Sample strobe and memory data
  input  wire logic                       sample_in,
  input  wire logic [sfs_pkg::DATA_W-1:0] dq_in,
  // Captured byte
  output logic      [sfs_pkg::STAT_W-1:0] status_out
);
  import sfs_pkg::*;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] next_status;

  always_comb begin
    next_status = sample_in ? dq_in[STAT_W-1:0] : status;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign status_out = status;
endmodule : sfs_status_capture
`default_nettype wire

// *** src/sfs_sequencer.sv ***
// Command triplet sequencer for a synchronous flash region
// How it works
// - A bus write into the flash region starts the program triplet instead of a plain write.
// - The program triplet opens with load-command-register and 0x40 on the low eight address bits.
// - During that first program command bank and upper address lines show the target.
// - The second program command is an activate with the target row and the same bank.
// - The third program command is a write with column, bank again and the data word.
// - No burst-terminate ever follows the program write.
// - A bus read into the region starts a status read opened by load-command-register with 0x70.
// - During that first status command bank and upper address lines show the read address.
// - The second status command is an activate with bank and row.
// - The third status command is a read with bank and column.
// - The status byte arrives on the low eight data lines after the CAS latency and is returned.
// - CAS latency of one, two or three clocks is configurable and times the sample.
// - At least the configured row-to-column delay separates activate from read or write.
`timescale 1ns/10ps
`default_nettype none
module sfs_sequencer (
  // Clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  // Configuration
  input  wire logic [1:0]                 cas_latency_setting_in,
  input  wire logic [sfs_pkg::CNT_W-1:0]  rcd_cycles_in,
  // Bus master request
  input  wire logic                       req_in,
  input  wire logic                       req_write_in,
  input  wire logic [sfs_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [sfs_pkg::DATA_W-1:0] req_wdata_in,
  // Bus master answer
  output logic                            busy_out,
  output logic                            done_out,
  output logic      [sfs_pkg::STAT_W-1:0] rdata_out,
  // Memory command bus
  output logic                            cs_n_out,
  output logic                            ras_n_out,
  output logic                            cas_n_out,
  output logic                            we_n_out,
  output logic      [sfs_pkg::BANK_W-1:0] ba_out,
  output logic      [sfs_pkg::MA_W-1:0]   ma_out,
  // Memory data bus
  input  wire logic [sfs_pkg::DATA_W-1:0] dq_in,
  output logic      [sfs_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe_out
);
  import sfs_pkg::*;

  // ===========================================================
  // Request latch and state
  sfs_state_type     state;
  sfs_state_type     next_state;
  logic              is_write;
  logic              next_is_write;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic [1:0]        cl;
  logic [1:0]        next_cl;
  logic [CNT_W-1:0]  rcd;
  logic [CNT_W-1:0]  next_rcd;

  // ===========================================================
  // Registered outputs
  logic [3:0]        cmd;
  logic [3:0]        next_cmd;
  logic [BANK_W-1:0] ba;
  logic [BANK_W-1:0] next_ba;
  logic [MA_W-1:0]   ma;
  logic [MA_W-1:0]   next_ma;
  logic [DATA_W-1:0] dq;
  logic [DATA_W-1:0] next_dq;
  logic              dq_oe;
  logic              next_dq_oe;
  logic              busy;
  logic              next_busy;
  logic              done;
  logic              next_done;

  // ===========================================================
  // Helpers
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_value;
  logic              cnt_zero;
  logic              sample;
  logic [STAT_W-1:0] status;
  logic [BANK_W-1:0] tgt_bank;
  logic [ROW_W-1:0]  tgt_row;
  logic [COL_W-1:0]  tgt_col;

  assign tgt_bank = addr[BANK_LSB +: BANK_W];
  assign tgt_row  = addr[ROW_LSB +: ROW_W];
  assign tgt_col  = addr[COL_LSB +: COL_W];

  sfs_delay_counter u_delay (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (cnt_load),
    .value_in   (cnt_value),
    .zero_out   (cnt_zero)
  );

  sfs_status_capture u_capture (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .sample_in  (sample),
    .dq_in      (dq_in),
    .status_out (status)
  );

  // ===========================================================
  // Next-state logic
  // One command per slot; any slot not named here is a NOP
  always_comb begin
    next_state = state;
    next_cmd   = CMD_NOP;
    next_ba    = ba;
    next_ma    = ma;
    cnt_load   = 1'b0;
    cnt_value  = '0;
    sample     = 1'b0;
    unique case (state)
      SFS_IDLE: begin
        if (req_in) begin
          next_state = SFS_LCR;
        end
      end
      SFS_LCR: begin
        next_cmd = CMD_LCR;
        next_ba  = tgt_bank;
        next_ma  = tgt_row;
        if (is_write) begin
          next_ma[CODE_W-1:0] = CODE_PROGRAM;
        end else begin
          next_ma[CODE_W-1:0] = CODE_STATUS;
        end
        next_state = SFS_ACT;
      end
      SFS_ACT: begin
        next_cmd   = CMD_ACTIVE;
        next_ba    = tgt_bank;
        next_ma    = tgt_row;
        // Counter covers the slots beyond the first one after activate
        cnt_load   = 1'b1;
        cnt_value  = rcd - 3'h1;
        next_state = SFS_RCD;
      end
      SFS_RCD: begin
        if (cnt_zero) begin
          next_ba = tgt_bank;
          next_ma = {{(MA_W-COL_W){1'b0}}, tgt_col};
          if (is_write) begin
            next_cmd   = CMD_WRITE;
            // Single write only: no burst-terminate is ever sent
            next_state = SFS_DONE;
          end else begin
            next_cmd   = CMD_READ;
            cnt_load   = 1'b1;
            cnt_value  = {1'b0, cl};
            next_state = SFS_LAT;
          end
        end
      end
      SFS_CMD: begin
        // Spare code off the usual path, leads straight to done
        next_state = SFS_DONE;
      end
      SFS_LAT: begin
        // Read command reaches the pins on the same edge that opens this state
        if (cnt_zero) begin
          sample     = 1'b1;
          next_state = SFS_DONE;
        end
      end
      SFS_DONE: begin
        next_state = SFS_IDLE;
      end
      default: begin
        // Illegal code: back to idle, the handshake recovers there
        next_state = SFS_IDLE;
      end
    endcase
  end

  // ===========================================================
  // Registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      // Deselect while in reset so the memory sees no command
      state <= SFS_IDLE;
      cmd   <= CMD_DESEL;
      ba    <= '0;
      ma    <= '0;
    end else begin
      state <= next_state;
      cmd   <= next_cmd;
      ba    <= next_ba;
      ma    <= next_ma;
    end
  end

  // ===========================================================
  // Request latch, loaded once per transfer
  always_comb begin
    next_is_write = is_write;
    next_addr     = addr;
    next_wdata    = wdata;
    next_cl       = cl;
    next_rcd      = rcd;
    if (state == SFS_IDLE && req_in) begin
      // Latch config per transfer so a change mid-triplet is harmless
      next_is_write = req_write_in;
      next_addr     = req_addr_in;
      next_wdata    = req_wdata_in;
      if (cas_latency_setting_in < CL_MIN) begin
        next_cl = CL_MIN;
      end else begin
        next_cl = cas_latency_setting_in;
      end
      // Zero would wrap the counter load to seven and stretch the delay to eight clocks
      if (rcd_cycles_in < RCD_MIN) begin
        next_rcd = RCD_MIN;
      end else begin
        next_rcd = rcd_cycles_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      is_write <= 1'b0;
      addr     <= '0;
      wdata    <= '0;
      cl       <= CL_MAX;
      rcd      <= RCD_MIN;
    end else begin
      is_write <= next_is_write;
      addr     <= next_addr;
      wdata    <= next_wdata;
      cl       <= next_cl;
      rcd      <= next_rcd;
    end
  end

  // ===========================================================
  // Bus master handshake
  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    if (state == SFS_IDLE) begin
      // Busy rises on the edge that takes the request
      next_busy = req_in;
    end else if (state == SFS_DONE) begin
      // Status byte is already settled when done pulses
      next_busy = 1'b0;
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      done <= next_done;
    end
  end

  // ===========================================================
  // Memory data lines
  always_comb begin
    next_dq    = dq;
    next_dq_oe = 1'b0;
    // Driven only in the write slot, so never against read data
    if (state == SFS_RCD && cnt_zero && is_write) begin
      next_dq    = wdata;
      next_dq_oe = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dq    <= '0;
      dq_oe <= 1'b0;
    end else begin
      dq    <= next_dq;
      dq_oe <= next_dq_oe;
    end
  end

  assign cs_n_out  = cmd[3];
  assign ras_n_out = cmd[2];
  assign cas_n_out = cmd[1];
  assign we_n_out  = cmd[0];
  assign ba_out    = ba;
  assign ma_out    = ma;
  assign dq_out    = dq;
  assign dq_oe_out = dq_oe;
  assign busy_out  = busy;
  assign done_out  = done;
  assign rdata_out = status;
endmodule : sfs_sequencer
`default_nettype wire

// *** verification/sfs_sequencer_asserts.sv ***
// Assertion checker for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module sfs_sequencer_asserts (
  // Clock, reset, request
  input wire logic                       clk_sys_in,
  input wire logic                       rst_in,
  input wire logic [1:0]                 cas_latency_setting_in,
  input wire logic [sfs_pkg::CNT_W-1:0]  rcd_cycles_in,
  input wire logic                       req_in,
  input wire logic                       req_write_in,
  input wire logic [sfs_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [sfs_pkg::DATA_W-1:0] req_wdata_in,
  // Answer and memory side
  input wire logic                       busy_out,
  input wire logic                       done_out,
  input wire logic [sfs_pkg::STAT_W-1:0] rdata_out,
  input wire logic                       cs_n_out,
  input wire logic                       ras_n_out,
  input wire logic                       cas_n_out,
  input wire logic                       we_n_out,
  input wire logic [sfs_pkg::BANK_W-1:0] ba_out,
  input wire logic [sfs_pkg::MA_W-1:0]   ma_out,
  input wire logic [sfs_pkg::DATA_W-1:0] dq_in,
  input wire logic [sfs_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe_out
);
  import sfs_pkg::*;
  // ==========================================================
  // Helper state
  logic [3:0]        cmd;
  logic              take;
  logic              wr_q;
  logic [ADDR_W-1:0] a_q;
  logic [DATA_W-1:0] d_q;
  logic [1:0]        cl_q;
  logic [1:0]        cl_e;
  logic [CNT_W-1:0]  rcd_q;
  logic [CNT_W-1:0]  rcd_e;
  logic [CNT_W-1:0]  act_n;
  logic [CNT_W-1:0]  rd_n;
  assign cmd   = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
  assign take  = req_in && !busy_out && !done_out;
  assign cl_e  = (cl_q == 2'h0) ? 2'h1 : cl_q;
  assign rcd_e = (rcd_q == 3'h0) ? 3'h1 : rcd_q;
  // Cycle counters since the last activate and read, saturating
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      act_n <= 3'h7;
      rd_n  <= 3'h7;
    end else begin
      act_n <= (cmd == CMD_ACTIVE) ? 3'h1 : act_n + {2'h0, act_n != 3'h7};
      rd_n  <= (cmd == CMD_READ) ? 3'h1 : rd_n + {2'h0, rd_n != 3'h7};
    end
    if (take) begin
      wr_q  <= req_write_in;
      a_q   <= req_addr_in;
      d_q   <= req_wdata_in;
      cl_q  <= cas_latency_setting_in;
      rcd_q <= rcd_cycles_in;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Properties
  property p_take;
    take |-> ##[1:2] cmd == CMD_LCR && busy_out;
  endproperty
  a_take: assert property (p_take)
    else $error("request not opened by load command");
  property p_lcr;
    cmd == CMD_LCR |-> ba_out == a_q[21:20] && ma_out[11:8] == a_q[19:16]
      && ma_out[7:0] == (wr_q ? CODE_PROGRAM : CODE_STATUS);
  endproperty
  a_lcr: assert property (p_lcr)
    else $error("wrong load command address");
  property p_lcr_act;
    cmd == CMD_LCR |=> cmd == CMD_ACTIVE;
  endproperty
  a_lcr_act: assert property (p_lcr_act)
    else $error("activate does not follow load command");
  property p_act;
    cmd == CMD_ACTIVE |-> ma_out == a_q[19:8] && ba_out == a_q[21:20];
  endproperty
  a_act: assert property (p_act)
    else $error("wrong activate address");
  property p_col;
    cmd == CMD_WRITE || cmd == CMD_READ |->
      ma_out[7:0] == a_q[7:0] && ba_out == a_q[21:20] && act_n == rcd_e;
  endproperty
  a_col: assert property (p_col)
    else $error("wrong column command address or delay");
  property p_wdata;
    cmd == CMD_WRITE |-> dq_oe_out && dq_out == d_q && wr_q;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write data not driven");
  property p_wr_end;
    cmd == CMD_WRITE |=> cmd == CMD_NOP && done_out && !busy_out;
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("program write not closed cleanly");
  property p_rd;
    rd_n == {1'b0, cl_e} + 3'h1 |-> rdata_out == $past(dq_in[7:0])
      ##1 done_out;
  endproperty
  a_rd: assert property (p_rd)
    else $error("status byte sampled at wrong time");
endmodule : sfs_sequencer_asserts
`default_nettype wire

// *** verification/sfs_flash_model.sv ***
// Behavioural flash memory seen across the command bus
`timescale 1ns/10ps
`default_nettype none
module sfs_flash_model (
  // Command bus
  input  wire logic                       clk_sys_in,
  input  wire logic [3:0]                 cmd_in,
  input  wire logic [sfs_pkg::BANK_W-1:0] ba_in,
  input  wire logic [sfs_pkg::MA_W-1:0]   ma_in,
  input  wire logic [sfs_pkg::DATA_W-1:0] data_in,
  // Setup from the bench
  input  wire logic [1:0]                 cl_in,
  input  wire logic [7:0]                 status_in,
  // Data lines and observations
  output logic      [sfs_pkg::DATA_W-1:0] dq_out,
  output logic      [7:0]                 code_out,
  output logic      [21:0]                addr_out,
  output logic      [sfs_pkg::DATA_W-1:0] word_out
);
  import sfs_pkg::*;
  int left = 0;
  initial dq_out = 16'h0000;
  always @(posedge clk_sys_in) begin
    if (cmd_in == CMD_LCR) code_out <= ma_in[7:0];
    if (cmd_in == CMD_ACTIVE) addr_out <= {ba_in, ma_in, 8'h00};
    if (cmd_in == CMD_WRITE) begin
      addr_out[7:0]   <= ma_in[7:0];
      addr_out[21:20] <= ba_in;
      word_out        <= data_in;
    end
    // Zero latency setting behaves as one clock
    if (cmd_in == CMD_READ) left = (cl_in == 2'h0) ? 1 : int'(cl_in);
    // Outside the data slot the lines toggle, never hold a stale byte
    if (left == 1) dq_out <= {~status_in, status_in};
    else dq_out <= ~dq_out;
    if (left != 0) left = left - 1;
  end
endmodule : sfs_flash_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sfs_pkg::*;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, req_in = 1'b0, req_w = 1'b0;
  logic [1:0]        cl = 2'h1;
  logic [CNT_W-1:0]  rcd = 3'h1;
  logic [ADDR_W-1:0] addr = 24'h000000;
  logic [DATA_W-1:0] wdata = 16'h0000, dq, dq_o, word;
  logic [7:0]        stat = 8'h00, rdata, code;
  logic [21:0]       paddr;
  logic              busy, done, cs_n, ras_n, cas_n, we_n, oe;
  logic [BANK_W-1:0] ba;
  logic [MA_W-1:0]   ma;
  int num_errors = 0, comparisons = 0, cycles = 0;
  sfs_sequencer DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cas_latency_setting_in(cl), .rcd_cycles_in(rcd), .req_in(req_in),
    .req_write_in(req_w), .req_addr_in(addr), .req_wdata_in(wdata),
    .busy_out(busy), .done_out(done), .rdata_out(rdata), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
    .ma_out(ma), .dq_in(dq), .dq_out(dq_o), .dq_oe_out(oe));
  sfs_flash_model u_mem (.clk_sys_in(clk_sys_in),
    .cmd_in({cs_n, ras_n, cas_n, we_n}), .ba_in(ba), .ma_in(ma),
    .data_in(dq_o), .cl_in(cl), .status_in(stat), .dq_out(dq),
    .code_out(code), .addr_out(paddr), .word_out(word));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // Ceiling well above the roughly 120 cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_sim();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic run_op(input logic w, input logic [23:0] a,
                        input logic [15:0] d, input logic [1:0] c,
                        input logic [2:0] r);
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    req_w  <= w;
    addr   <= a;
    wdata  <= d;
    cl     <= c;
    rcd    <= r;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    repeat (30) begin
      @(posedge clk_sys_in);
      #1;
      if (done === 1'b1) break;
    end
    check(done === 1'b1, "transfer not completed");
  endtask : run_op
  task automatic prog(input logic [23:0] a, input logic [15:0] d,
                      input logic [2:0] r);
    run_op(1'b1, a, d, 2'h2, r);
    check(code === 8'h40, "program code");
    check(paddr === a[21:0], "program address");
    check(word === d, "program word");
  endtask : prog
  task automatic stat_rd(input logic [23:0] a, input logic [1:0] c);
    stat <= a[7:0] ^ {6'h2A, c};
    run_op(1'b0, a, 16'hFFFF, c, 3'h2);
    check(code === 8'h70, "status code");
    check(paddr[21:8] === a[21:8], "status row");
    check(rdata === (a[7:0] ^ {6'h2A, c}), "status byte");
  endtask : stat_rd
  // ==========================================================
  // Scenarios
  task automatic t_program();
    for (int i = 0; i < 4; i++) begin
      prog({2'h3, 2'(i), 12'hA5C ^ 12'(i), 8'hF0 + 8'(i)},
           16'h8001 << i, 3'(2 * i + 1));
    end
    $display("test program done");
  endtask : t_program
  task automatic t_status();
    // Setting zero included: it must run as one clock
    for (int c = 0; c < 4; c++) begin
      stat_rd({2'h0, 2'(c), 12'h3C7, 8'h0F * 8'(c)}, 2'(c));
    end
    $display("test status done");
  endtask : t_status
  task automatic t_back2back();
    prog(24'h1FFFFF, 16'hFFFF, 3'h0);
    stat_rd(24'h200000, 2'h3);
    prog(24'h000000, 16'h0000, 3'h7);
    $display("test back to back done");
  endtask : t_back2back
  task automatic t_reset();
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    req_w  <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    req_in <= 1'b0;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    check(busy === 1'b0, "busy after reset");
    stat_rd(24'h12345A, 2'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_program();
    t_status();
    t_back2back();
    t_reset();
    end_sim();
  end
endmodule : tb_top
bind sfs_sequencer sfs_sequencer_asserts u_chk (.*);
`default_nettype wire
